// ### rtl/csfr_top.sv
// core special-function register bank with apb slave, port latches and clock out
// assumes a single 20 MHz clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
`include "csfr_defs.svh"

module csfr_top
  import csfr_pkg::*;
#(
  parameter csfr_variant_t VARIANT = CSFR_LARGE,
  parameter int PC_WIDTH = 11
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire csfr_ports_t PORT_PINS_IN,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [31:0] PRDATA_OUT,
  output csfr_ports_t PORT_LATCH_OUT,
  output csfr_ports_t DIR_CTRL_OUT,
  output logic [PC_WIDTH-1:0] PC_OUT,
  output logic [5:0] OPTION_OUT,
  output logic OSC_RETURN_PIN_OUT
);

  localparam int NBANK = (VARIANT == CSFR_LARGE) ? 8 : (VARIANT == CSFR_MID) ? 4 : 1;

  // five-bit file addresses for the decoders
  localparam logic [4:0] FA_WINDOW = 5'(`CSFR_IDX_WINDOW);
  localparam logic [4:0] FA_TIMER = 5'(`CSFR_IDX_TIMER);
  localparam logic [4:0] FA_PCL = 5'(`CSFR_IDX_PCL);
  localparam logic [4:0] FA_FLAGS = 5'(`CSFR_IDX_FLAGS);
  localparam logic [4:0] FA_POINTER = 5'(`CSFR_IDX_POINTER);
  localparam logic [4:0] FA_PORT_A = 5'(`CSFR_IDX_PORT_A);
  localparam logic [4:0] FA_PORT_B = 5'(`CSFR_IDX_PORT_B);
  localparam logic [4:0] FA_PORT_C = 5'(`CSFR_IDX_PORT_C);
  localparam logic [4:0] FA_PORT_D = 5'(`CSFR_IDX_PORT_D);
  localparam logic [4:0] FA_PORT_E = 5'(`CSFR_IDX_PORT_E);

  logic [7:0] timer_count;
  logic [7:0] pc_low_byte;
  logic [PC_WIDTH-9:0] pc_high;
  logic [7:0] core_flags;
  logic [7:0] indirect_pointer;
  logic rc_mode;
  logic [1:0] clk_div;
  logic [7:0] gpr_mem [0:NBANK*32-1];
  logic [5:0] idx;
  logic addr_ok;
  logic is_file;
  logic setup;
  logic access;
  logic [4:0] tgt;
  logic [2:0] bank;
  logic [7:0] file_rd;
  logic [31:0] next_rdata;
  logic tgt_is_gpr;
  logic wr_bus;
  logic wr_file;

  // pointer bits as software sees them
  function automatic logic [7:0] ptr_view(input logic [7:0] p);
    case (VARIANT)
      CSFR_SMALL: ptr_view = {3'h7, p[4:0]};
      CSFR_MID: ptr_view = {1'h1, p[6:0]};
      default: ptr_view = p;
    endcase
  endfunction

  // bank picked by the pointer upper bits
  function automatic logic [2:0] ptr_bank(input logic [7:0] p);
    case (VARIANT)
      CSFR_SMALL: ptr_bank = 3'h0;
      CSFR_MID: ptr_bank = {1'h0, p[6:5]};
      default: ptr_bank = p[7:5];
    endcase
  endfunction

  // whether a file address holds general-purpose storage
  function automatic logic is_gpr(input logic [4:0] a);
    if (a >= 5'h0a) begin
      is_gpr = 1'b1;
    end else if (a == 5'h07) begin
      is_gpr = (VARIANT == CSFR_SMALL);
    end else if (a == 5'h08 || a == 5'h09) begin
      is_gpr = (VARIANT != CSFR_LARGE);
    end else begin
      is_gpr = 1'b0;
    end
  endfunction

  // storage index; low half of the file is common to all banks
  function automatic int gpr_index(input logic [4:0] a, input logic [2:0] b);
    if (a < `CSFR_BANKED_FROM || int'(b) >= NBANK) begin
      gpr_index = int'(a);
    end else begin
      gpr_index = int'(b) * 32 + int'(a);
    end
  endfunction

  assign setup = PSEL_IN && !PENABLE_IN;
  assign access = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign idx = PADDR_IN[7:2];
  assign is_file = (PADDR_IN[11:7] == 5'h00);
  assign addr_ok = (PADDR_IN[1:0] == 2'h0) && (is_file || (PADDR_IN[11:8] == 4'h0
    && idx >= `CSFR_IDX_DIR_SET && idx <= `CSFR_IDX_CONFIG));

  // redirect the window through the pointer
  always_comb begin
    if (idx[4:0] == FA_WINDOW) begin
      tgt = indirect_pointer[4:0];
    end else begin
      tgt = idx[4:0];
    end
    bank = ptr_bank(indirect_pointer);
  end

  assign tgt_is_gpr = is_gpr(tgt);

  always_comb begin
    file_rd = 8'h00;
    if (tgt_is_gpr) begin
      file_rd = gpr_mem[gpr_index(tgt, bank)];
    end else begin
      case (tgt)
        FA_WINDOW: file_rd = 8'h00;
        FA_TIMER: file_rd = timer_count;
        FA_PCL: file_rd = pc_low_byte;
        FA_FLAGS: file_rd = core_flags;
        FA_POINTER: file_rd = ptr_view(indirect_pointer);
        FA_PORT_A: file_rd = PORT_PINS_IN.a & `CSFR_PORT_A_MASK;
        FA_PORT_B: file_rd = PORT_PINS_IN.b;
        FA_PORT_C: file_rd = PORT_PINS_IN.c;
        FA_PORT_D: file_rd = PORT_PINS_IN.d;
        FA_PORT_E: file_rd = PORT_PINS_IN.e & `CSFR_PORT_E_MASK;
        default: file_rd = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (is_file) begin
      next_rdata = {24'h00_0000, file_rd};
    end else if (idx == `CSFR_IDX_CONFIG) begin
      next_rdata = {29'h0000_0000, VARIANT, rc_mode};
    end
  end

  // zero-wait apb: ready prepared at the setup edge
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PREADY_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= setup;
    end
  end

  // unmapped or misaligned addresses are refused, never stored
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PSLVERR_OUT <= 1'b0;
    end else begin
      PSLVERR_OUT <= setup && !addr_ok;
    end
  end

  // read data holds until the next setup cycle
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (setup) begin
      PRDATA_OUT <= addr_ok && !PWRITE_IN ? next_rdata : 32'h0000_0000;
    end
  end

  // writes land at the access edge only
  assign wr_bus = access && PWRITE_IN && addr_ok;
  assign wr_file = wr_bus && is_file;

  always_ff @(posedge CLK_IN) begin
    if (wr_file && tgt_is_gpr) begin
      gpr_mem[gpr_index(tgt, bank)] <= PWDATA_IN[7:0];
    end
  end

  // window target 00h matches no register below: stores nothing
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      timer_count <= 8'h00;
    end else if (wr_file && tgt == FA_TIMER) begin
      timer_count <= PWDATA_IN[7:0];
    end
  end

  // upper pc bits have no file address and keep their reset value
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      pc_low_byte <= `CSFR_PCL_RESET;
      pc_high <= '1;
    end else if (wr_file && tgt == FA_PCL) begin
      pc_low_byte <= PWDATA_IN[7:0];
    end
  end

  // bits 4:3 are read-only flags; the bus changes only the others
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      core_flags <= `CSFR_FLAGS_RESET;
    end else if (wr_file && tgt == FA_FLAGS) begin
      core_flags <= (core_flags & ~`CSFR_FLAGS_WR_MASK)
        | (PWDATA_IN[7:0] & `CSFR_FLAGS_WR_MASK);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      indirect_pointer <= 8'h00;
    end else if (wr_file && tgt == FA_POINTER) begin
      indirect_pointer <= PWDATA_IN[7:0];
    end
  end

  // port latches drive the pins from the next cycle on
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PORT_LATCH_OUT <= '0;
    end else if (wr_file && !tgt_is_gpr) begin
      case (tgt)
        FA_PORT_A: PORT_LATCH_OUT.a <= PWDATA_IN[7:0] & `CSFR_PORT_A_MASK;
        FA_PORT_B: PORT_LATCH_OUT.b <= PWDATA_IN[7:0];
        FA_PORT_C: PORT_LATCH_OUT.c <= PWDATA_IN[7:0];
        FA_PORT_D: PORT_LATCH_OUT.d <= PWDATA_IN[7:0];
        FA_PORT_E: PORT_LATCH_OUT.e <= PWDATA_IN[7:0] & `CSFR_PORT_E_MASK;
        default: ;
      endcase
    end
  end

  // direction set outside the data file; bits 10:8 pick the port
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      DIR_CTRL_OUT <= {5{`CSFR_DIR_RESET}};
    end else if (wr_bus && idx == `CSFR_IDX_DIR_SET) begin
      case (PWDATA_IN[10:8])
        3'h0: DIR_CTRL_OUT.a <= PWDATA_IN[7:0];
        3'h1: DIR_CTRL_OUT.b <= PWDATA_IN[7:0];
        3'h2: DIR_CTRL_OUT.c <= PWDATA_IN[7:0];
        3'h3: DIR_CTRL_OUT.d <= PWDATA_IN[7:0];
        3'h4: DIR_CTRL_OUT.e <= PWDATA_IN[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      OPTION_OUT <= `CSFR_OPTION_RESET;
    end else if (wr_bus && idx == `CSFR_IDX_OPTION) begin
      OPTION_OUT <= PWDATA_IN[5:0];
    end
  end

  // rc oscillator mode enables the quarter-rate clock out
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      rc_mode <= 1'b0;
    end else if (wr_bus && idx == `CSFR_IDX_CONFIG) begin
      rc_mode <= PWDATA_IN[0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PC_OUT <= '1;
    end else begin
      PC_OUT <= {pc_high, pc_low_byte};
    end
  end

  // toggle every two cycles: a quarter of the input rate
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || !rc_mode) begin
      clk_div <= 2'h0;
      OSC_RETURN_PIN_OUT <= 1'b0;
    end else begin
      clk_div <= (clk_div == `CSFR_CLK_DIV_HALF) ? 2'h0 : clk_div + 2'h1;
      if (clk_div == `CSFR_CLK_DIV_HALF) begin
        OSC_RETURN_PIN_OUT <= !OSC_RETURN_PIN_OUT;
      end
    end
  end

endmodule // csfr_top

`default_nettype wire

// ### rtl/csfr_defs.svh
// constants of the core special-function register bank
// assumes an apb slave with 32-bit data, one register per aligned word
//
// How it works
// - in rc oscillator mode the return pin carries a quarter-rate clock.
// - pc low byte at 02h shows pc bits 7:0, resets to ff.
// - pc upper bits have no data-file address at all.
// - smallest variant pointer resets 111x xxxx, upper three bits read one.
// - mid variant pointer resets 1xxx xxxx; largest variant fully undefined.
// - unimplemented register bits read back as zero, except unused pointer bits, which read one.
// - port a bits 7:4 and port e bits 3:0 read zero.
// - on the smallest variant 07h is general-purpose storage, not port c.
// - on small and mid variants 08h and 09h are general-purpose storage.
// - direction registers have no data-file address and reset to ff.
// - the indirect window redirects to the address held in the pointer.
// - indirect access to the window itself reads 00h and writes nothing.
// - pointer bits 4:0 pick the address; upper bits pick the bank.
`ifndef CSFR_DEFS_SVH
`define CSFR_DEFS_SVH

`define CSFR_IDX_WINDOW 6'h00
`define CSFR_IDX_TIMER 6'h01
`define CSFR_IDX_PCL 6'h02
`define CSFR_IDX_FLAGS 6'h03
`define CSFR_IDX_POINTER 6'h04
`define CSFR_IDX_PORT_A 6'h05
`define CSFR_IDX_PORT_B 6'h06
`define CSFR_IDX_PORT_C 6'h07
`define CSFR_IDX_PORT_D 6'h08
`define CSFR_IDX_PORT_E 6'h09
`define CSFR_IDX_DIR_SET 6'h20
`define CSFR_IDX_OPTION 6'h21
`define CSFR_IDX_CONFIG 6'h22

`define CSFR_BANKED_FROM 5'h10
`define CSFR_PCL_RESET 8'hff
`define CSFR_DIR_RESET 8'hff
`define CSFR_OPTION_RESET 6'h3f
`define CSFR_FLAGS_RESET 8'h18
`define CSFR_FLAGS_WR_MASK 8'he7
`define CSFR_PORT_A_MASK 8'h0f
`define CSFR_PORT_E_MASK 8'hf0
`define CSFR_CLK_DIV_HALF 2'h1

`endif

// ### rtl/csfr_pkg.sv
// types of the core special-function register bank
package csfr_pkg;

  typedef enum logic [1:0] {
    CSFR_SMALL = 2'h0,
    CSFR_MID = 2'h1,
    CSFR_LARGE = 2'h2
  } csfr_variant_t;

  typedef struct packed {
    logic [7:0] e;
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } csfr_ports_t;

endpackage : csfr_pkg

// ### tb/csfr_chk.sv
// checker for the register bank's bus and pin behaviour
// assumes bind into csfr_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module csfr_chk #(
  parameter int PC_WIDTH = 11
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic [PC_WIDTH-1:0] PC_OUT,
  input wire logic OSC_RETURN_PIN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  wire logic setup = PSEL_IN && !PENABLE_IN;
  wire logic rd = setup && !PWRITE_IN;

  ready_after_setup_a: assert property (setup |=> PREADY_OUT)
    else $error("ready missing");
  ready_one_cycle_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready too long");
  ready_has_cause_a: assert property (PREADY_OUT |-> $past(setup))
    else $error("ready without setup");
  unmapped_refused_a: assert property (setup && PADDR_IN[7:2] > 6'h22
    |=> PSLVERR_OUT && PRDATA_OUT == 32'h0) else $error("no refusal");
  upper_bits_zero_a: assert property (PREADY_OUT && !PADDR_IN[7]
    |-> PRDATA_OUT[31:8] == 24'h0) else $error("upper bits set");
  port_a_zero_a: assert property (rd && PADDR_IN == 12'h014
    |=> PRDATA_OUT[7:4] == 4'h0) else $error("port a high bits");
  port_e_zero_a: assert property (rd && PADDR_IN == 12'h024
    |=> PRDATA_OUT[3:0] == 4'h0) else $error("port e low bits");
  pc_upper_ones_a: assert property (&PC_OUT[PC_WIDTH-1:8])
    else $error("pc upper bits");
  quarter_clock_a: assert property ($rose(OSC_RETURN_PIN_OUT)
    |=> OSC_RETURN_PIN_OUT ##1 !OSC_RETURN_PIN_OUT [*2] ##1 OSC_RETURN_PIN_OUT)
    else $error("clock out not quarter rate");
endmodule // csfr_chk

bind csfr_top csfr_chk #(.PC_WIDTH(PC_WIDTH)) i_csfr_chk (
  .CLK_IN, .RESET_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PREADY_OUT,
  .PSLVERR_OUT, .PRDATA_OUT, .PC_OUT, .OSC_RETURN_PIN_OUT);
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for csfr_top, large variant
// assumes csfr_pkg and the checker compiled first
`timescale 1ns/10ps
`default_nettype none
module tb
  import csfr_pkg::*;
;
  logic clk, rst, psel, pen, pwr, rerr, ready, err, osc, prev;
  logic [11:0] paddr;
  logic [31:0] pwd, rdata, rdat, dat;
  logic [5:0] idx, opt;
  logic [10:0] pc;
  csfr_ports_t pins, latch, dir;
  int failures, check_count, k, n;

  csfr_top i_csfr_top (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PORT_PINS_IN(pins),
    .PREADY_OUT(ready), .PSLVERR_OUT(err), .PRDATA_OUT(rdata), .PORT_LATCH_OUT(latch),
    .DIR_CTRL_OUT(dir), .PC_OUT(pc), .OPTION_OUT(opt), .OSC_RETURN_PIN_OUT(osc));

  always #25 clk = ~clk;

  task automatic finish_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {4'h0, i, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ready !== 1'b1 && t < 16);
    if (ready !== 1'b1) begin
      failures++;
      finish_test();
    end else begin
      rdat = rdata;
      rerr = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask

  function automatic logic [7:0] pin_view(input int i, input csfr_ports_t p);
    case (i)
      5: return p.a & 8'h0f;
      6: return p.b;
      7: return p.c;
      8: return p.d;
      default: return p.e & 8'hf0;
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h0;
    pwd = 32'h0;
    pins = '0;
    void'($urandom(32'h1a491057));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(dir, {5{8'hff}});
    chk(pc, 11'h7ff);
    chk(osc, 1'b0);
    chk(opt, 6'h3f);
    apb(1'b0, 6'h02, 32'h0);
    chk(rdat, 32'hff);
    apb(1'b0, 6'h04, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, 6'h03, 32'h0);
    apb(1'b0, 6'h03, 32'h0);
    chk(rdat, 32'h18);
    for (k = 0; k < 6; k++) begin
      idx = 6'h0a + 6'($urandom_range(21));
      dat = $urandom;
      apb(1'b1, idx, dat);
      apb(1'b0, idx, 32'h0);
      chk(rdat, {24'h0, dat[7:0]});
      apb(1'b1, 6'h04, {26'h0, idx});
      apb(1'b0, 6'h00, 32'h0);
      chk(rdat, {24'h0, dat[7:0]});
    end
    apb(1'b1, 6'h04, 32'h0);
    apb(1'b1, 6'h00, 32'h55);
    apb(1'b0, 6'h00, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, 6'h02, 32'h3c);
    @(posedge clk);
    chk(pc, 11'h73c);
    pins <= {$urandom, 8'($urandom)};
    dat = $urandom;
    apb(1'b1, 6'h06, dat);
    @(posedge clk);
    chk(latch.b, dat[7:0]);
    for (k = 5; k < 10; k++) begin
      apb(1'b0, 6'(k), 32'h0);
      chk(rdat, {24'h0, pin_view(k, pins)});
    end
    apb(1'b0, 6'h23, 32'h0);
    chk({rerr, rdat}, {1'b1, 32'h0});
    apb(1'b1, 6'h20, {21'h0, 3'h1, 8'h5a});
    @(posedge clk);
    chk(dir.b, 8'h5a);
    apb(1'b1, 6'h21, {26'h0, 6'h2a});
    @(posedge clk);
    chk(opt, 6'h2a);
    // same banked address in bank k and bank 0 holds two values
    k = 1 + int'($urandom_range(6));
    idx = 6'h10 + 6'($urandom_range(15));
    dat = $urandom;
    apb(1'b1, 6'h04, {24'h0, 3'(k), idx[4:0]});
    apb(1'b1, 6'h00, {24'h0, dat[7:0]});
    apb(1'b1, 6'h04, {27'h0, idx[4:0]});
    apb(1'b1, 6'h00, {24'h0, ~dat[7:0]});
    apb(1'b0, 6'h00, 32'h0);
    chk(rdat, {24'h0, ~dat[7:0]});
    apb(1'b1, 6'h04, {24'h0, 3'(k), idx[4:0]});
    apb(1'b0, 6'h00, 32'h0);
    chk(rdat, {24'h0, dat[7:0]});
    apb(1'b0, idx, 32'h0);
    chk(rdat, {24'h0, dat[7:0]});
    apb(1'b0, 6'h04, 32'h0);
    chk(rdat, {24'h0, 3'(k), idx[4:0]});
    apb(1'b1, 6'h22, 32'h1);
    repeat (8) @(posedge clk);
    n = 0;
    prev = osc;
    repeat (16) begin
      @(posedge clk);
      if (osc && !prev) n++;
      prev = osc;
    end
    chk(40'(n), 40'h4);
    finish_test();
  end
endmodule // tb
`default_nettype wire
